// *** include/zcd_pkg.sv ***
package zcd_pkg;
   // byte addresses of the block's registers
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_GLOBAL = 8'h10;
   // control register fields
   localparam int CTRL_SOFTWARE_ENABLE_BIT = 7;
   localparam int CTRL_INVERT_SELECT_BIT = 4;
   localparam int CTRL_RISE_IRQ_ENABLE_BIT = 1;
   localparam int CTRL_FALL_IRQ_ENABLE_BIT = 0;
   // status register fields
   localparam int STATUS_OUT_BIT = 5;
   localparam int STATUS_ACTIVE_BIT = 6;
   // flag and enable layout: bit 0 is the crossing flag
   localparam int FLAG_CROSSING_BIT = 0;
   // global enable register fields
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int GLOBAL_LOW_PRIO_BIT = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] GLOBAL_RESET = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic software_enable;
      logic invert_select;
      logic rise_irq_enable;
      logic fall_irq_enable;
   } zcd_ctrl_t;

   typedef struct packed {
      logic rise;
      logic fall;
      logic invert_change;
   } zcd_events_t;
endpackage : zcd_pkg

// *** src/zcd_sync.sv ***
`timescale 1ns/10ps
module zcd_sync (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_sync
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage1_next;
   logic stage2_next;

   // two flops; only the second reads the first
   always_comb begin
      stage1_next = i_async;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end else if (i_ce) begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign o_sync = stage2_reg;
endmodule : zcd_sync

// *** src/zcd_edge.sv ***
`timescale 1ns/10ps
module zcd_edge (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_level,
   output logic o_rise,
   output logic o_fall
);
   logic prev_reg;
   logic prev_next;

   always_comb begin
      prev_next = i_level;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         prev_reg <= 1'b0;
      end else if (i_ce) begin
         prev_reg <= prev_next;
      end
   end

   assign o_rise = i_ce & i_level & ~prev_reg;
   assign o_fall = i_ce & ~i_level & prev_reg;
endmodule : zcd_edge

// *** src/zcd_top.sv ***
// Functional notes
// R1: without inversion, output high while sink active, low while source active.
// R2: invert select set flips the output: high means source active.
// R3: edge detection works on the polarity-adjusted output.
// R4: rising and falling detectors set the crossing flag when their enable is set.
// R5: rise and fall enables gate their detectors independently.
// R6: irq only when flag, crossing enable and both global enables set; a flag set by an invert change raises irq with no edge enable set.
// R7: a write changing invert select is an edge event, regardless of software enable.
// R8: set wins over a software clear in the same cycle.
// R9: software clears the flag; hardware never clears it.
// R10: polarity-adjusted output exported for other on-chip modules.
// R11: fuse clear means always enabled; fuse set means software enable decides.
// R12: analog sink indication passes a two-stage synchroniser first.
`timescale 1ns/10ps
module zcd_top (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_config_fuse,
   input wire logic i_sink_active,
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_crossing_out,
   output logic o_detector_active,
   output logic o_irq
);
   logic sink_sync;
   logic active;
   logic logic_out;
   logic rise_det;
   logic fall_det;
   zcd_pkg::zcd_ctrl_t ctrl_reg;
   zcd_pkg::zcd_ctrl_t ctrl_next;
   logic crossing_flag_reg;
   logic crossing_flag_next;
   logic crossing_irq_enable_reg;
   logic crossing_irq_enable_next;
   logic global_irq_enable_reg;
   logic global_irq_enable_next;
   logic low_priority_global_enable_reg;
   logic low_priority_global_enable_next;
   logic wr_pend_reg;
   logic wr_pend_next;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_addr_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic out_reg;
   logic out_next;
   logic addr_phase;
   logic wr_ctrl;
   logic wr_clear;
   logic inv_change;
   zcd_pkg::zcd_events_t ev;

   zcd_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_async(i_sink_active), // R12
      .o_sync(sink_sync)
   );

   // fuse clear forces the detector on
   assign active = ~i_config_fuse | ctrl_reg.software_enable; // R11
   // sink active gives high unless inverted; idle detector reads low
   assign logic_out = active & (sink_sync ^ ctrl_reg.invert_select); // R1 R2

   zcd_edge u_edge (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_level(logic_out), // R3
      .o_rise(rise_det),
      .o_fall(fall_det)
   );

   assign addr_phase = i_hsel & i_hready & (i_htrans == zcd_pkg::HTRANS_NONSEQ);
   assign wr_ctrl = wr_pend_reg & (wr_addr_reg == zcd_pkg::ADDR_CTRL);
   assign wr_clear = wr_pend_reg & (wr_addr_reg == zcd_pkg::ADDR_IRQ_CLEAR)
      & i_hwdata[zcd_pkg::FLAG_CROSSING_BIT];
   assign inv_change = wr_ctrl
      & (i_hwdata[zcd_pkg::CTRL_INVERT_SELECT_BIT] != ctrl_reg.invert_select);

   always_comb begin
      ev.rise = rise_det & ctrl_reg.rise_irq_enable; // R4 R5
      ev.fall = fall_det & ctrl_reg.fall_irq_enable; // R4 R5
      ev.invert_change = inv_change; // R7
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      crossing_irq_enable_next = crossing_irq_enable_reg;
      global_irq_enable_next = global_irq_enable_reg;
      low_priority_global_enable_next = low_priority_global_enable_reg;
      wr_pend_next = addr_phase & i_hwrite;
      wr_addr_next = addr_phase ? i_haddr : wr_addr_reg;
      rdata_next = rdata_reg;
      out_next = logic_out;
      if (wr_ctrl) begin
         ctrl_next.software_enable = i_hwdata[zcd_pkg::CTRL_SOFTWARE_ENABLE_BIT];
         ctrl_next.invert_select = i_hwdata[zcd_pkg::CTRL_INVERT_SELECT_BIT];
         ctrl_next.rise_irq_enable = i_hwdata[zcd_pkg::CTRL_RISE_IRQ_ENABLE_BIT];
         ctrl_next.fall_irq_enable = i_hwdata[zcd_pkg::CTRL_FALL_IRQ_ENABLE_BIT];
      end
      if (wr_pend_reg && wr_addr_reg == zcd_pkg::ADDR_IRQ_ENABLE) begin
         crossing_irq_enable_next = i_hwdata[zcd_pkg::FLAG_CROSSING_BIT];
      end
      if (wr_pend_reg && wr_addr_reg == zcd_pkg::ADDR_IRQ_GLOBAL) begin
         global_irq_enable_next = i_hwdata[zcd_pkg::GLOBAL_IRQ_ENABLE_BIT];
         low_priority_global_enable_next = i_hwdata[zcd_pkg::GLOBAL_LOW_PRIO_BIT];
      end
      // clear first, then set, so a same-cycle event wins
      crossing_flag_next = crossing_flag_reg & ~wr_clear; // R9
      if (ev.rise || ev.fall || ev.invert_change) begin
         crossing_flag_next = 1'b1; // R8
      end
      if (addr_phase && !i_hwrite) begin
         rdata_next = 32'h0000_0000;
         case (i_haddr)
            zcd_pkg::ADDR_CTRL: begin
               rdata_next[zcd_pkg::CTRL_SOFTWARE_ENABLE_BIT] = ctrl_reg.software_enable;
               rdata_next[zcd_pkg::STATUS_OUT_BIT] = logic_out;
               rdata_next[zcd_pkg::CTRL_INVERT_SELECT_BIT] = ctrl_reg.invert_select;
               rdata_next[zcd_pkg::CTRL_RISE_IRQ_ENABLE_BIT] = ctrl_reg.rise_irq_enable;
               rdata_next[zcd_pkg::CTRL_FALL_IRQ_ENABLE_BIT] = ctrl_reg.fall_irq_enable;
            end
            zcd_pkg::ADDR_STATUS: begin
               rdata_next[zcd_pkg::FLAG_CROSSING_BIT] = crossing_flag_reg;
               rdata_next[zcd_pkg::STATUS_OUT_BIT] = logic_out;
               rdata_next[zcd_pkg::STATUS_ACTIVE_BIT] = active;
            end
            zcd_pkg::ADDR_IRQ_ENABLE: begin
               rdata_next[zcd_pkg::FLAG_CROSSING_BIT] = crossing_irq_enable_reg;
            end
            zcd_pkg::ADDR_IRQ_GLOBAL: begin
               rdata_next[zcd_pkg::GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_reg;
               rdata_next[zcd_pkg::GLOBAL_LOW_PRIO_BIT] = low_priority_global_enable_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ctrl_reg <= zcd_pkg::zcd_ctrl_t'(zcd_pkg::CTRL_RESET[3:0]);
         crossing_flag_reg <= 1'b0;
         crossing_irq_enable_reg <= 1'b0;
         global_irq_enable_reg <= zcd_pkg::GLOBAL_RESET[zcd_pkg::GLOBAL_IRQ_ENABLE_BIT];
         low_priority_global_enable_reg <= zcd_pkg::GLOBAL_RESET[zcd_pkg::GLOBAL_LOW_PRIO_BIT];
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
         out_reg <= 1'b0;
      end else if (i_ce) begin
         ctrl_reg <= ctrl_next;
         crossing_flag_reg <= crossing_flag_next;
         crossing_irq_enable_reg <= crossing_irq_enable_next;
         global_irq_enable_reg <= global_irq_enable_next;
         low_priority_global_enable_reg <= low_priority_global_enable_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
         out_reg <= out_next;
      end
   end

   assign o_hrdata = rdata_reg;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_crossing_out = out_reg; // R10
   assign o_detector_active = active;
   // edge enables already gate the flag, the rest gate the line
   assign o_irq = crossing_flag_reg & crossing_irq_enable_reg & global_irq_enable_reg
      & low_priority_global_enable_reg; // R6

   // assertions
   output_polarity_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_ce |=> (o_crossing_out == $past(logic_out)))
      else $error("crossing output does not follow adjusted level"); // R10
   polarity_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      active |-> (logic_out == (sink_sync ^ ctrl_reg.invert_select)))
      else $error("polarity mapping wrong"); // R1
   invert_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (active && ctrl_reg.invert_select) |-> (logic_out == !sink_sync))
      else $error("inverted mapping wrong"); // R2
   rise_sets_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && rise_det && ctrl_reg.rise_irq_enable) |=> crossing_flag_reg)
      else $error("rising edge did not set flag"); // R4
   fall_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && !crossing_flag_reg && !inv_change && !(rise_det && ctrl_reg.rise_irq_enable)
      && !(fall_det && ctrl_reg.fall_irq_enable)) |=> !crossing_flag_reg)
      else $error("flag set without enabled event"); // R5
   edge_source_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && $changed(logic_out) && logic_out && $past(i_ce)) |-> rise_det)
      else $error("rise not seen on adjusted output"); // R3
   invert_event_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && inv_change) |=> crossing_flag_reg)
      else $error("invert change did not set flag"); // R7
   set_wins_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && wr_clear && (ev.rise || ev.fall)) |=> crossing_flag_reg)
      else $error("clear won over set"); // R8
   flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (crossing_flag_reg && !(i_ce && wr_clear)) |=> crossing_flag_reg)
      else $error("flag dropped without clear"); // R9
   irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_irq |-> (crossing_irq_enable_reg && global_irq_enable_reg
      && low_priority_global_enable_reg && crossing_flag_reg))
      else $error("irq without all enables"); // R6
   fuse_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !i_config_fuse |-> o_detector_active)
      else $error("detector off with fuse clear"); // R11
   sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && $past(i_ce) && $past(i_ce, 2)) |-> (sink_sync == $past(i_sink_active, 2)))
      else $error("synchroniser depth wrong"); // R12

   // further guards on flag, line and level paths
   fall_sets_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && fall_det && ctrl_reg.fall_irq_enable) |=> crossing_flag_reg)
      else $error("falling edge did not set flag"); // R4
   flag_cause_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $rose(crossing_flag_reg) |-> $past(ev.rise || ev.fall || ev.invert_change))
      else $error("flag rose without an event"); // R4
   edge_excl_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      rise_det |-> !fall_det)
      else $error("rise and fall in one cycle"); // R4
   fall_source_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && $changed(logic_out) && !logic_out && $past(i_ce)) |-> fall_det)
      else $error("fall not seen on adjusted output"); // R3
   plain_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (active && !ctrl_reg.invert_select) |-> (logic_out == sink_sync))
      else $error("plain mapping wrong"); // R1
   idle_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !active |-> !logic_out)
      else $error("idle detector level not low"); // R1
   clear_works_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && wr_clear && !ev.rise && !ev.fall && !ev.invert_change) |=> !crossing_flag_reg)
      else $error("clear did not drop flag"); // R9
   irq_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (crossing_flag_reg && crossing_irq_enable_reg && global_irq_enable_reg
      && low_priority_global_enable_reg) |-> o_irq)
      else $error("irq missing with all enables"); // R6
   sen_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_config_fuse |-> (o_detector_active == ctrl_reg.software_enable))
      else $error("software enable not obeyed"); // R11
   idle_out_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && !active) |=> !o_crossing_out)
      else $error("exported level high while idle"); // R10
   sync_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_ce && $past(i_ce)) |-> (sink_sync == $past(u_sync.stage1_reg)))
      else $error("second stage skipped"); // R12

   clear_cover: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) wr_clear);
   rise_cover: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) ev.rise);
   fall_cover: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) ev.fall);
   inv_cover: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) inv_change);
   irq_cover: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) o_irq);
endmodule : zcd_top

// *** dv/zcd_ac_source.sv ***
`timescale 1ns/10ps
// far side: ac waveform through a series resistor; the analog stage sinks
// while the waveform is above the reference and sources while it is below
module zcd_ac_source #(
   parameter realtime SETTLE_NS = 7.0
) (
   input wire logic i_above_ref,
   output logic o_sink_active
);
   // the sink/source swap lands off the clock edge, a fixed SETTLE_NS after the rising edge that drove it
   initial o_sink_active = 1'b0;
   always @(i_above_ref) begin
      o_sink_active <= #(SETTLE_NS) i_above_ref;
   end
endmodule : zcd_ac_source

// *** dv/zcd_top_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module zcd_top_test;
   logic clk, rst_n, fuse, above, sink, hwrite, hready, crossing, det_act, irq, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, d;
   int failures, n_tests, cycles;
   zcd_ac_source #(.SETTLE_NS(7.0)) ac (.i_above_ref(above), .o_sink_active(sink));
   zcd_top DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_config_fuse(fuse),
      .i_sink_active(sink), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .o_crossing_out(crossing), .o_detector_active(det_act), .o_irq(irq));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      htrans <= zcd_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      d = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      ahb(a, 1'b1, wd);
   endtask : wr
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      `CHK("register read", e, d)
   endtask : chk_reg
   task automatic chk_flag(input logic e);
      ahb(zcd_pkg::ADDR_STATUS, 1'b0, 32'h0);
      `CHK("crossing flag", e, d[zcd_pkg::FLAG_CROSSING_BIT])
   endtask : chk_flag
   task automatic set_ac(input logic v);
      @(posedge clk);
      above <= v;
      repeat (6) @(posedge clk);
   endtask : set_ac
   task automatic clr_flag();
      wr(zcd_pkg::ADDR_IRQ_CLEAR, 32'h1);
      chk_flag(1'b0);
   endtask : clr_flag
   task automatic t_reset();
      chk_reg(zcd_pkg::ADDR_CTRL, 32'h0);
      chk_reg(zcd_pkg::ADDR_STATUS, 32'h40);
      chk_reg(zcd_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk_reg(zcd_pkg::ADDR_IRQ_GLOBAL, 32'h0);
      wr(8'h20, 32'hff);
      chk_reg(8'h20, 32'h0);
      `CHK("irq after reset", 1'b0, irq)
      `CHK("response okay", 1'b0, hresp)
      $display("test reset done");
   endtask : t_reset
   task automatic t_polarity();
      set_ac(1'b1);
      `CHK("out sink", 1'b1, crossing)
      chk_reg(zcd_pkg::ADDR_STATUS, 32'h60);
      set_ac(1'b0);
      `CHK("out source", 1'b0, crossing)
      wr(zcd_pkg::ADDR_CTRL, 32'h10);
      repeat (2) @(posedge clk);
      `CHK("inverted source", 1'b1, crossing)
      set_ac(1'b1);
      `CHK("inverted sink", 1'b0, crossing)
      set_ac(1'b0);
      wr(zcd_pkg::ADDR_CTRL, 32'h0);
      clr_flag();
      $display("test polarity done");
   endtask : t_polarity
   task automatic t_edges();
      wr(zcd_pkg::ADDR_CTRL, 32'h02);
      set_ac(1'b1);
      chk_flag(1'b1);
      clr_flag();
      set_ac(1'b0);
      chk_flag(1'b0);
      wr(zcd_pkg::ADDR_CTRL, 32'h01);
      set_ac(1'b1);
      chk_flag(1'b0);
      set_ac(1'b0);
      chk_flag(1'b1);
      clr_flag();
      wr(zcd_pkg::ADDR_CTRL, 32'h11);
      clr_flag();
      set_ac(1'b1);
      chk_flag(1'b1);
      clr_flag();
      set_ac(1'b0);
      chk_flag(1'b0);
      $display("test edges done");
   endtask : t_edges
   task automatic t_invert_event();
      wr(zcd_pkg::ADDR_CTRL, 32'h0);
      fuse <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      `CHK("detector off", 1'b0, det_act)
      clr_flag();
      wr(zcd_pkg::ADDR_CTRL, 32'h10);
      chk_flag(1'b1);
      repeat (50) @(posedge clk);
      chk_flag(1'b1);
      wr(zcd_pkg::ADDR_CTRL, 32'h90);
      @(posedge clk);
      `CHK("detector on", 1'b1, det_act)
      $display("test invert event done");
   endtask : t_invert_event
   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         wr(zcd_pkg::ADDR_IRQ_ENABLE, {31'h0, i[0]});
         wr(zcd_pkg::ADDR_IRQ_GLOBAL, {24'h0, i[2], 1'b0, i[1], 5'h0});
         @(posedge clk);
         `CHK("irq gating", (i == 7), irq)
      end
      wr(zcd_pkg::ADDR_IRQ_CLEAR, 32'h1);
      @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      $display("test irq done");
   endtask : t_irq
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      failures = 0;
      n_tests = 0;
      cycles = 0;
      rst_n = 1'b0;
      fuse = 1'b0;
      above = 1'b0;
      htrans = 2'h0;
      haddr = 8'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_polarity();
      t_edges();
      t_invert_event();
      t_irq();
      complete_run();
   end
endmodule : zcd_top_test
